// >>> asq_pkg.sv
package asq_pkg;

    // core clock and internal oscillator
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_START_NS  = 125;
    localparam int OSC_START_CYC_I =
        (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] OSC_START_CYC = 3'(OSC_START_CYC_I > 0 ? OSC_START_CYC_I : 1);
    localparam int OSC_DIV_DEFAULT = 10;

    // serial-peripheral command phase
    localparam logic [4:0] SPI_CMD_BITS = 5'd8;
    localparam logic [4:0] SPI_CHAN_EDGE = 5'd3;
    localparam logic [4:0] SPI_CMD_CLKS = 5'd16;

    // internal-clock conversion timing, in oscillator cycles
    localparam logic [5:0] ACQ_START_RISE = 6'd2;
    localparam logic [5:0] ACQ_END_FALL   = 6'd18;
    localparam logic [5:0] INT_CYCLES     = 6'd32;

    // result word: 14 code bits then two tail bits
    localparam int RESULT_BITS = 14;
    localparam int WORD_BITS   = 16;
    localparam int MAX_SCAN    = 8;

    // command fields
    localparam int CHAN_MSB = 7;
    localparam int CHAN_LSB = 5;
    localparam int SCAN_MSB = 4;
    localparam int SCAN_LSB = 3;

    // frame-synchronised mode edges
    localparam logic [5:0] DSP_CHAN_EDGE  = 6'd3;
    localparam logic [5:0] DSP8_CMD_END   = 6'd8;
    localparam logic [5:0] DSP8_SAMPLE    = 6'd7;
    localparam logic [5:0] DSP8_FSO       = 6'd8;
    localparam logic [5:0] DSP16_CMD_END  = 6'd16;
    localparam logic [5:0] DSP16_SAMPLE   = 6'd15;
    localparam logic [5:0] DSP16_FSO      = 6'd16;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_CMD      = 3'b001,
        ST_OSC_WAIT = 3'b011,
        ST_CONVERT  = 3'b010,
        ST_READ     = 3'b110,
        ST_DSP_WAIT = 3'b111,
        ST_DSP_XFER = 3'b101
    } asq_state_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic fs_in;
        logic width_sel;
    } asq_pins_s;

endpackage : asq_pkg

// >>> asq_sequencer.sv
`timescale 1ns/10ps
module asq_sequencer #(
    parameter int OSC_DIV = asq_pkg::OSC_DIV_DEFAULT
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       din,
    input  wire logic       frame_sync_in,
    input  wire logic       transfer_width_select,
    input  wire logic       conv_bit,
    input  wire logic       result_tail_bit_hi,
    input  wire logic       result_tail_bit_lo,
    output logic            dout,
    output logic            dout_oe,
    output logic            conv_done_n,
    output logic            frame_sync_out,
    output logic            analog_wake,
    output logic            osc_run,
    output logic            acquire,
    output logic            sample_strobe,
    output logic [2:0]      channel,
    output logic            dsp_mode
);

    if (OSC_DIV < 4 || OSC_DIV > 255) begin : g_bad_div
        $error("OSC_DIV must lie in 4..255");
    end

    localparam logic [7:0] DIV_LAST = 8'(OSC_DIV - 1);
    localparam logic [7:0] DIV_HALF = 8'(OSC_DIV / 2);

    // conversions for each scan setting; 11 repeats one channel
    function automatic logic [3:0] scan_count(input logic [1:0] sel);
        case (sel)
            2'b00:   scan_count = 4'h1;
            2'b01:   scan_count = 4'h4;
            default: scan_count = 4'h8;
        endcase
    endfunction : scan_count

    logic [1:0]              rst_pipe;
    logic                    rst_n;
    asq_pkg::asq_pins_s      pin_s1;
    asq_pkg::asq_pins_s      pin_s2;
    asq_pkg::asq_pins_s      pin_s3;
    asq_pkg::asq_pins_s      pin_raw;
    asq_pkg::asq_state_e     state;
    logic [7:0]              cmd;
    logic [4:0]              edge_cnt;
    logic [2:0]              delay;
    logic [7:0]              div;
    logic [5:0]              icyc;
    logic [2:0]              conv_idx;
    logic [3:0]              conv_total;
    logic                    scan_same;
    logic [12:0]             code_sreg;
    logic [15:0]             out_word;
    logic [3:0]              bit_cnt;
    logic [2:0]              rd_idx;
    logic [5:0]              fcnt;
    logic [5:0]              rcnt;
    logic                    wide;
    logic [15:0]             result_mem [asq_pkg::MAX_SCAN];
    logic                    mem_we;
    logic [15:0]             conv_word;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // every pin is asynchronous to core_clk; stage 3 only serves edge finding
    assign pin_raw = '{cs_n: cs_n, sclk: sclk, din: din,
                       fs_in: frame_sync_in, width_sel: transfer_width_select};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '{cs_n: 1'b1, default: 1'b0};
            pin_s2 <= '{cs_n: 1'b1, default: 1'b0};
            pin_s3 <= '{cs_n: 1'b1, default: 1'b0};
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic fs_rise;
    logic fs_fall;
    logic tick_rise;
    logic tick_fall;
    logic [5:0] rnext;
    logic [5:0] fnext;
    logic [5:0] cmd_end;
    logic [5:0] sample_edge;
    logic [5:0] fso_edge;
    logic [5:0] data_idx;

    assign sclk_rise   = pin_s2.sclk & ~pin_s3.sclk;
    assign sclk_fall   = ~pin_s2.sclk & pin_s3.sclk;
    assign cs_fall     = pin_s3.cs_n & ~pin_s2.cs_n;
    assign cs_rise     = ~pin_s3.cs_n & pin_s2.cs_n;
    assign fs_rise     = pin_s2.fs_in & ~pin_s3.fs_in;
    assign fs_fall     = ~pin_s2.fs_in & pin_s3.fs_in;
    assign tick_rise   = (div == 8'h00);
    assign tick_fall   = (div == DIV_HALF);
    assign rnext       = (rcnt == 6'h3f) ? rcnt : 6'(rcnt + 6'h01);
    assign fnext       = (fcnt == 6'h3f) ? fcnt : 6'(fcnt + 6'h01);
    assign cmd_end     = wide ? asq_pkg::DSP16_CMD_END : asq_pkg::DSP8_CMD_END;
    assign sample_edge = wide ? asq_pkg::DSP16_SAMPLE : asq_pkg::DSP8_SAMPLE;
    assign fso_edge    = wide ? asq_pkg::DSP16_FSO : asq_pkg::DSP8_FSO;
    assign data_idx    = 6'(rnext - fso_edge - 6'h01);

    // finished word: code MSB first, then tail bits; plain binary code
    assign conv_word = {code_sreg, conv_bit, result_tail_bit_hi, result_tail_bit_lo};
    assign mem_we    = (state == asq_pkg::ST_CONVERT) && tick_fall
                       && (icyc == asq_pkg::INT_CYCLES) && !cs_rise;

    // results stay buffered until the whole scan is done
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            result_mem[conv_idx] <= conv_word;
        end
    end

    // oscillator divider; runs only while converting
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 8'h00;
        end else if (state != asq_pkg::ST_CONVERT) begin
            div <= 8'h00;
        end else begin
            div <= (div == DIV_LAST) ? 8'h00 : 8'(div + 8'h01);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state          <= asq_pkg::ST_IDLE;
            cmd            <= 8'h00;
            edge_cnt       <= 5'h00;
            delay          <= 3'h0;
            icyc           <= 6'h00;
            conv_idx       <= 3'h0;
            conv_total     <= 4'h1;
            scan_same      <= 1'b0;
            code_sreg      <= 13'h0000;
            out_word       <= 16'h0000;
            bit_cnt        <= 4'h0;
            rd_idx         <= 3'h0;
            fcnt           <= 6'h00;
            rcnt           <= 6'h00;
            wide           <= 1'b0;
            dout           <= 1'b0;
            dout_oe        <= 1'b0;
            conv_done_n    <= 1'b1;
            frame_sync_out <= 1'b0;
            analog_wake    <= 1'b0;
            osc_run        <= 1'b0;
            acquire        <= 1'b0;
            sample_strobe  <= 1'b0;
            channel        <= 3'h0;
            dsp_mode       <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            if (cs_rise) begin
                // abort whatever runs and fall back to shutdown
                state          <= asq_pkg::ST_IDLE;
                dout           <= 1'b0;
                dout_oe        <= 1'b0;
                conv_done_n    <= 1'b1;
                frame_sync_out <= 1'b0;
                analog_wake    <= 1'b0;
                osc_run        <= 1'b0;
                acquire        <= 1'b0;
                dsp_mode       <= 1'b0;
            end else begin
                case (state)
                    asq_pkg::ST_IDLE: begin
                        if (cs_fall) begin
                            dout     <= 1'b0;
                            dout_oe  <= 1'b1;
                            cmd      <= 8'h00;
                            edge_cnt <= 5'h00;
                            dsp_mode <= ~pin_s2.fs_in;
                            if (pin_s2.fs_in) begin
                                analog_wake <= 1'b1;
                                state       <= asq_pkg::ST_CMD;
                            end else begin
                                state <= asq_pkg::ST_DSP_WAIT;
                            end
                        end
                    end
                    asq_pkg::ST_CMD: begin
                        if (sclk_rise) begin
                            edge_cnt <= 5'(edge_cnt + 5'h01);
                            if (edge_cnt < asq_pkg::SPI_CMD_BITS) begin
                                cmd <= {cmd[6:0], pin_s2.din};
                            end
                            if (5'(edge_cnt + 5'h01) == asq_pkg::SPI_CHAN_EDGE) begin
                                channel <= {cmd[1:0], pin_s2.din};
                            end
                            if (5'(edge_cnt + 5'h01) == asq_pkg::SPI_CMD_CLKS) begin
                                conv_total <= scan_count(cmd[asq_pkg::SCAN_MSB:asq_pkg::SCAN_LSB]);
                                scan_same  <= &cmd[asq_pkg::SCAN_MSB:asq_pkg::SCAN_LSB];
                                if (cmd[asq_pkg::SCAN_MSB:asq_pkg::SCAN_LSB] == 2'b10) begin
                                    channel <= 3'h0;
                                end
                                delay <= 3'h0;
                                state <= asq_pkg::ST_OSC_WAIT;
                            end
                        end
                    end
                    asq_pkg::ST_OSC_WAIT: begin
                        // serial clock is expected to stand still from here
                        delay <= 3'(delay + 3'h1);
                        if (3'(delay + 3'h1) == asq_pkg::OSC_START_CYC) begin
                            osc_run  <= 1'b1;
                            icyc     <= 6'h01;
                            conv_idx <= 3'h0;
                            state    <= asq_pkg::ST_CONVERT;
                        end
                    end
                    asq_pkg::ST_CONVERT: begin
                        if (tick_rise && icyc == asq_pkg::ACQ_START_RISE) begin
                            acquire <= 1'b1;
                        end
                        if (tick_fall) begin
                            icyc <= (icyc == asq_pkg::INT_CYCLES) ? 6'h01 : 6'(icyc + 6'h01);
                            if (icyc == asq_pkg::ACQ_END_FALL) begin
                                acquire       <= 1'b0;
                                sample_strobe <= 1'b1;
                            end
                            if (icyc > asq_pkg::ACQ_END_FALL) begin
                                code_sreg <= {code_sreg[11:0], conv_bit};
                            end
                            if (icyc == asq_pkg::INT_CYCLES) begin
                                // 32 oscillator cycles per conversion
                                if (4'({1'b0, conv_idx} + 4'h1) == conv_total) begin
                                    conv_done_n <= 1'b0;
                                    osc_run     <= 1'b0;
                                    analog_wake <= 1'b0;
                                    out_word    <= (conv_idx == 3'h0) ? conv_word : result_mem[0];
                                    dout        <= (conv_idx == 3'h0) ? conv_word[15]
                                                                      : result_mem[0][15];
                                    bit_cnt     <= 4'h0;
                                    rd_idx      <= 3'h0;
                                    state       <= asq_pkg::ST_READ;
                                end else begin
                                    conv_idx <= 3'(conv_idx + 3'h1);
                                    if (!scan_same) begin
                                        channel <= 3'(channel + 3'h1);
                                    end
                                end
                            end
                        end
                    end
                    asq_pkg::ST_READ: begin
                        if (sclk_fall) begin
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                            if (bit_cnt == 4'hf) begin
                                // after the last word the sequence starts again
                                rd_idx   <= (4'({1'b0, rd_idx} + 4'h1) == conv_total)
                                            ? 3'h0 : 3'(rd_idx + 3'h1);
                                out_word <= result_mem[(4'({1'b0, rd_idx} + 4'h1) == conv_total)
                                                       ? 3'h0 : 3'(rd_idx + 3'h1)];
                                dout     <= result_mem[(4'({1'b0, rd_idx} + 4'h1) == conv_total)
                                                       ? 3'h0 : 3'(rd_idx + 3'h1)][15];
                            end else begin
                                out_word <= {out_word[14:0], 1'b0};
                                dout     <= out_word[14];
                            end
                        end
                    end
                    asq_pkg::ST_DSP_WAIT: begin
                        if (fs_rise) begin
                            analog_wake <= 1'b1;
                        end
                        if (fs_fall) begin
                            analog_wake <= 1'b1;
                            fcnt        <= 6'h00;
                            rcnt        <= 6'h00;
                            cmd         <= 8'h00;
                            wide        <= pin_s2.width_sel;
                            state       <= asq_pkg::ST_DSP_XFER;
                        end
                    end
                    asq_pkg::ST_DSP_XFER: begin
                        if (fs_rise) begin
                            // a new frame drops the running conversion
                            acquire        <= 1'b0;
                            frame_sync_out <= 1'b0;
                            dout           <= 1'b0;
                            state          <= asq_pkg::ST_DSP_WAIT;
                        end else begin
                            if (sclk_fall) begin
                                fcnt <= fnext;
                                if (fcnt < cmd_end && fcnt < 6'd8) begin
                                    cmd <= {cmd[6:0], pin_s2.din};
                                end
                                if (fnext == asq_pkg::DSP_CHAN_EDGE) begin
                                    channel <= {cmd[1:0], pin_s2.din};
                                    acquire <= 1'b1;
                                end
                            end
                            if (sclk_rise) begin
                                rcnt <= rnext;
                                if (rnext == sample_edge) begin
                                    acquire       <= 1'b0;
                                    sample_strobe <= 1'b1;
                                end
                                frame_sync_out <= (rnext == fso_edge);
                                if (rnext <= fso_edge) begin
                                    dout <= 1'b0;
                                end else if (data_idx < 6'(asq_pkg::RESULT_BITS)) begin
                                    dout <= conv_bit;
                                end else if (data_idx == 6'(asq_pkg::RESULT_BITS)) begin
                                    dout <= result_tail_bit_hi;
                                end else if (data_idx == 6'(asq_pkg::RESULT_BITS + 1)) begin
                                    dout <= result_tail_bit_lo;
                                end else begin
                                    dout <= 1'b0;
                                end
                            end
                        end
                    end
                    default: begin
                        state <= asq_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : asq_sequencer

// >>> asq_assertions.sv
`timescale 1ns/10ps
module asq_assertions #(
    parameter int OSC_DIV = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic conv_done_n,
    input wire logic frame_sync_out,
    input wire logic analog_wake,
    input wire logic osc_run,
    input wire logic acquire,
    input wire logic sample_strobe,
    input wire logic dsp_mode
);
    // acquisition spans internal rise 2 to fall 18, allow half a period each side
    localparam int ACQ_LO = 16 * OSC_DIV;
    localparam int ACQ_HI = 17 * OSC_DIV;
    logic [9:0] acq_cnt;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acq_cnt <= 10'h0;
        end else if (acquire) begin
            acq_cnt <= acq_cnt + 10'h1;
        end else begin
            acq_cnt <= 10'h0;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_off;
        !dout_oe && !analog_wake && !osc_run;
    endsequence
    sequence s_fso_pulse;
        frame_sync_out [*8] ##1 !frame_sync_out;
    endsequence

    property p_wake_on;  $fell(cs_n) |-> ##[1:5] dout_oe; endproperty
    property p_cs_abort; $rose(cs_n) |-> ##[1:5] s_off; endproperty
    property p_idle_off; !dout_oe |-> !analog_wake && !osc_run && !acquire; endproperty
    property p_done_off;
        $fell(conv_done_n) |-> !osc_run && !analog_wake && dout_oe;
    endproperty
    property p_acq_len;
        $fell(acquire) && !dsp_mode && dout_oe && analog_wake
            |-> acq_cnt >= ACQ_LO && acq_cnt <= ACQ_HI;
    endproperty
    property p_osc_mode; osc_run |-> !dsp_mode && conv_done_n && analog_wake; endproperty
    property p_fso_len;  $rose(frame_sync_out) |-> s_fso_pulse; endproperty
    property p_fso_dsp;  $rose(frame_sync_out) |-> dsp_mode && !acquire && !osc_run; endproperty
    property p_sample;   sample_strobe |-> !acquire && $past(acquire); endproperty

    a_wake_on:  assert property (p_wake_on)  else $error("no drive after select");
    a_cs_abort: assert property (p_cs_abort) else $error("deselect did not shut down");
    a_idle_off: assert property (p_idle_off) else $error("active while deselected");
    a_done_off: assert property (p_done_off) else $error("done without shutdown");
    a_acq_len:  assert property (p_acq_len)  else $error("acquisition length wrong");
    a_osc_mode: assert property (p_osc_mode) else $error("oscillator in wrong mode");
    a_fso_len:  assert property (p_fso_len)  else $error("sync out length wrong");
    a_fso_dsp:  assert property (p_fso_dsp)  else $error("sync out at wrong time");
    a_sample:   assert property (p_sample)   else $error("sample without acquisition end");
endmodule : asq_assertions

// >>> asq_host_model.sv
`timescale 1ns/10ps
module asq_host_model (
    input  wire logic core_clk,
    input  wire logic dout,
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    output logic      frame_sync_in,
    output logic      transfer_width_select
);
    logic        dm;
    logic [15:0] rd [0:8];

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        frame_sync_in = 1'b1;
        transfer_width_select = 1'b0;
        dm = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_clk

    // one 200 ns serial clock; data moves mid-phase so both sync paths agree
    task automatic tick(input logic b, output logic s);
        sclk <= 1'b0;
        wait_clk(2);
        if (!dm) din <= b;
        wait_clk(2);
        s = dout;
        sclk <= 1'b1;
        wait_clk(2);
        if (dm) din <= b;
        wait_clk(2);
    endtask : tick

    task automatic spi_cmd(input logic [7:0] cmd);
        logic s;
        dm = 1'b0;
        cs_n <= 1'b0;
        wait_clk(6);
        for (int j = 0; j < 16; j++) tick(j < 8 ? cmd[7 - j] : 1'b0, s);
        sclk <= 1'b0;
    endtask : spi_cmd

    task automatic read_words(input int nw);
        logic s;
        for (int w = 0; w < nw; w++) begin
            for (int j = 15; j >= 0; j--) begin
                tick(1'b0, s);
                rd[w][j] = s;
            end
        end
    endtask : read_words

    task automatic release_cs();
        cs_n <= 1'b1;
        wait_clk(6);
    endtask : release_cs

    task automatic dsp_enter();
        sclk <= 1'b1;
        frame_sync_in <= 1'b0;
        wait_clk(4);
        cs_n <= 1'b0;
        wait_clk(8);
    endtask : dsp_enter

    // clock idles high so the first falling edge after sync is a real one
    task automatic dsp_frame(input logic [7:0] cmd, input logic wide, input int nt);
        logic s;
        int   p;
        dm = 1'b1;
        transfer_width_select <= wide;
        din <= cmd[7];
        frame_sync_in <= 1'b1;
        wait_clk(8);
        frame_sync_in <= 1'b0;
        wait_clk(8);
        for (int j = 1; j <= nt; j++) begin
            tick(j < 8 ? cmd[7 - j] : 1'b0, s);
            p = j - (wide ? 18 : 10);
            if (p >= 0 && p < 32) rd[p / 16][15 - p % 16] = s;
        end
    endtask : dsp_frame
endmodule : asq_host_model

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int OSC_DIV = 4;
    logic core_clk, resetn, conv_bit, sclk_q, fs_q;
    wire  cs_n, sclk, din, frame_sync_in, transfer_width_select;
    logic dout, dout_oe, conv_done_n, frame_sync_out, analog_wake, osc_run, acquire, dsp_mode;
    logic [2:0]  channel;
    logic [13:0] code, oc;
    int          err_total, compares, nrise, ocnt, ph, bi;

    asq_sequencer #(.OSC_DIV(OSC_DIV)) DUT (.core_clk(core_clk), .resetn(resetn),
        .cs_n(cs_n), .sclk(sclk), .din(din), .frame_sync_in(frame_sync_in),
        .transfer_width_select(transfer_width_select), .conv_bit(conv_bit),
        .result_tail_bit_hi(1'b1), .result_tail_bit_lo(1'b0), .dout(dout),
        .dout_oe(dout_oe), .conv_done_n(conv_done_n), .frame_sync_out(frame_sync_out),
        .analog_wake(analog_wake), .osc_run(osc_run), .acquire(acquire),
        .sample_strobe(), .channel(channel), .dsp_mode(dsp_mode));
    asq_host_model u_host (.core_clk(core_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk),
        .din(din), .frame_sync_in(frame_sync_in),
        .transfer_width_select(transfer_width_select));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // analog core stand-in: internal mode keyed to oscillator cycles, frame mode to serial rises
    always @(posedge core_clk) begin
        sclk_q <= sclk;
        fs_q <= frame_sync_in;
        ph = (ocnt / OSC_DIV) % 32;
        bi = (transfer_width_select ? 29 : 21) - nrise;
        oc = code + 14'(ocnt / (32 * OSC_DIV));
        if (fs_q && !frame_sync_in) nrise <= 0;
        else if (!sclk_q && sclk) nrise <= nrise + 1;
        ocnt <= osc_run ? ocnt + 1 : 0;
        if (osc_run && ph >= 18) conv_bit <= oc[31 - ph];
        else if (sclk_q && !sclk && bi >= 0 && bi < 14) conv_bit <= code[bi];
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic t_spi(input logic [1:0] sc, input int nw);
        int k;
        code = 14'h2d5a ^ {12'h0, sc};
        u_host.spi_cmd({3'h5, sc, 3'h0});
        k = 0;
        while (conv_done_n !== 1'b0 && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        chk("done_osc_wake", 16'h0, {13'h0, conv_done_n, osc_run, analog_wake});
        u_host.read_words(nw + 1);
        for (int w = 0; w < nw; w++) chk("word", {code + 14'(w), 2'b10}, u_host.rd[w]);
        if (nw == 1) chk("repeat", {code, 2'b10}, u_host.rd[1]);
        if (sc == 2'h0) chk("channel", 16'h5, {13'h0, channel});
        u_host.release_cs();
    endtask : t_spi

    task automatic t_abort();
        int k;
        u_host.spi_cmd(8'ha0);
        k = 0;
        while (osc_run !== 1'b1 && k < 50) begin
            @(posedge core_clk);
            k++;
        end
        u_host.wait_clk(100);
        u_host.release_cs();
        chk("abort", 16'h0, {13'h0, osc_run, analog_wake, dout_oe});
    endtask : t_abort

    task automatic t_dsp();
        u_host.dsp_enter();
        chk("dsp_mode", 16'h1, {15'h0, dsp_mode});
        for (int m = 0; m < 2; m++) begin
            code = m ? 14'h1b3c : 14'h3a65;
            u_host.dsp_frame(8'hc0, m[0], m ? 49 : 41);
            chk("dsp_word", {code, 2'b10}, u_host.rd[0]);
            chk("dsp_zeros", 16'h0, u_host.rd[1]);
            chk("dsp_chan", 16'h6, {13'h0, channel});
        end
        code = 14'h0f0f;
        u_host.dsp_frame(8'h40, 1'b0, 10);
        u_host.dsp_frame(8'h20, 1'b0, 41);
        chk("restart_word", {code, 2'b10}, u_host.rd[0]);
        chk("restart_chan", 16'h1, {13'h0, channel});
        u_host.release_cs();
        chk("dsp_off", 16'h0, {15'h0, analog_wake});
    endtask : t_dsp

    initial begin
        resetn = 1'b0;
        conv_bit = 1'b0;
        code = 14'h0;
        err_total = 0;
        compares = 0;
        nrise = 0;
        ocnt = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        t_spi(2'h0, 1);
        t_spi(2'h1, 4);
        t_spi(2'h2, 8);
        t_spi(2'h3, 8);
        t_abort();
        t_dsp();
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
endmodule : tb_top

bind asq_sequencer asq_assertions #(.OSC_DIV(OSC_DIV)) u_chk (.core_clk(core_clk),
    .resetn(resetn), .cs_n(cs_n), .dout_oe(dout_oe), .conv_done_n(conv_done_n),
    .frame_sync_out(frame_sync_out), .analog_wake(analog_wake), .osc_run(osc_run),
    .acquire(acquire), .sample_strobe(sample_strobe), .dsp_mode(dsp_mode));
